// *** rtl/srpc_top.sv ***
// Purpose: Sleep mode clock gating and reset-pin control
// Assumes: Pins synchronous to clk, fuses static
// Notes: Pull-up and output enables are active low
// Operation
// - Idle stops the CPU but keeps memory, timers, SPI and interrupts clocked.
// - Power-down stops the oscillator and everything else until interrupt or reset.
// - Power-save keeps the asynchronous timer counting.
// - Conversion-quiet stops all but the asynchronous timer, the ADC and the oscillator.
// - Standby keeps the oscillator running so wake needs no start-up delay.
// - Five sleep modes are selectable by software.
// - Every port pin floats while any reset is active.
// - A long enough low on the reset pin resets the device.
// - The reset-disable fuse turns the reset pin into port C bit 6.
// - With the RC clock and async select set, port B bits 7 and 6 take the timer crystal.
// - Clock fuses give port B bits 6 and 7 to the main oscillator amplifier.
// - Ports B and D are 8-bit bidirectional with per-bit pull-ups.
// - Port C has per-bit pull-ups and bits 5 to 0 are always port bits.
`timescale 1ns/1ps
`include "srpc_regs.svh"
module srpc_top
  import srpc_pkg::*;
#(
  parameter int W = `SRPC_PORT_W,
  parameter int RST_MIN_CYC = `SRPC_RST_MIN_CYC,
  parameter int OSC_START_CYC = `SRPC_OSC_START_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sleep control
  input wire logic sleep_enable,
  input wire logic sleep_req,
  input wire srpc_pkg::srpc_mode_t sleep_mode,
  input wire logic irq_pending,
  input wire logic other_reset,
  // Fuses and clock selection
  input wire logic reset_pin_disable_fuse,
  input wire logic rc_osc_selected,
  input wire logic ext_osc_on_pins,
  input wire logic async_timer_clock_select,
  // Port control from core
  input wire logic [W-1:0] port_b_out,
  input wire logic [W-1:0] port_b_dir,
  input wire logic [W-1:0] port_b_pull,
  input wire logic [W-1:0] port_c_out,
  input wire logic [W-1:0] port_c_dir,
  input wire logic [W-1:0] port_c_pull,
  input wire logic [W-1:0] port_d_out,
  input wire logic [W-1:0] port_d_dir,
  input wire logic [W-1:0] port_d_pull,
  // Pins
  input wire logic [W-1:0] port_b_in,
  input wire logic [W-1:0] port_c_in,
  input wire logic [W-1:0] port_d_in,
  output logic [W-1:0] port_b_o,
  output logic [W-1:0] port_b_oe_n,
  output logic [W-1:0] port_b_pu_n,
  output logic [W-1:0] port_c_o,
  output logic [W-1:0] port_c_oe_n,
  output logic [W-1:0] port_c_pu_n,
  output logic [W-1:0] port_d_o,
  output logic [W-1:0] port_d_oe_n,
  output logic [W-1:0] port_d_pu_n,
  // Status
  output logic device_reset,
  output logic timer_crystal_pins,
  output logic main_osc_pins,
  output srpc_pkg::srpc_clk_en_t clk_en,
  output srpc_pkg::srpc_state_t state
);
  import srpc_pkg::*;

  srpc_rst_if rif ();
  srpc_state_t st_q, st_d;
  srpc_mode_t mode_q;
  srpc_clk_en_t en_q;
  srpc_clk_en_t mode_q_en;
  logic [15:0] wcnt_q;
  logic rst_any;
  logic [W-1:0] b_shared;
  logic [W-1:0] c_avail;

  // Clock enables per mode
  function automatic srpc_clk_en_t mode_en(input srpc_mode_t m);
    srpc_clk_en_t e;
    e = '{cpu: 1'b0, io: 1'b0, async_tmr: 1'b0, adc: 1'b0, osc: 1'b0};
    case (m)
      SRPC_MODE_IDLE: e = '{cpu: 1'b0, io: 1'b1, async_tmr: 1'b1, adc: 1'b1, osc: 1'b1};
      SRPC_MODE_ADCQ: e = '{cpu: 1'b0, io: 1'b0, async_tmr: 1'b1, adc: 1'b1, osc: 1'b1};
      SRPC_MODE_PSAVE: e.async_tmr = 1'b1;
      SRPC_MODE_STBY: e.osc = 1'b1;
      default: e = '{cpu: 1'b0, io: 1'b0, async_tmr: 1'b0, adc: 1'b0, osc: 1'b0};
    endcase
    return e;
  endfunction : mode_en

  // Reset pin unless fused as port C bit 6
  assign rif.pin_low = !reset_pin_disable_fuse && !port_c_in[`SRPC_PC_BIT_SIX];
  srpc_rst_filter #(.MIN_CYC(RST_MIN_CYC)) u_filt (.clk(clk), .rstn(rstn), .rif(rif));
  assign rst_any = !rstn || rif.rst_req || other_reset;

  // Pins lost to oscillator or timer crystal
  always_comb begin
    b_shared = '0;
    if (ext_osc_on_pins || (rc_osc_selected && async_timer_clock_select)) begin
      b_shared[`SRPC_PB_BIT_SIX] = 1'b1;
      b_shared[`SRPC_PB_BIT_SEVEN] = 1'b1;
    end
    c_avail = '0;
    c_avail[5:0] = '1;
    c_avail[`SRPC_PC_BIT_SIX] = reset_pin_disable_fuse;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= SRPC_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      SRPC_ST_RUN: if (rst_any) st_d = SRPC_ST_RST;
        else if (sleep_enable && sleep_req && sleep_mode <= SRPC_MODE_STBY) st_d = SRPC_ST_SLEEP;
      SRPC_ST_SLEEP: if (rst_any) st_d = SRPC_ST_RST;
        else if (irq_pending) st_d = SRPC_ST_WAKE;
      SRPC_ST_WAKE: if (rst_any) st_d = SRPC_ST_RST;
        else if (wcnt_q == 16'h0) st_d = SRPC_ST_RUN;
      SRPC_ST_RST: if (!rst_any) st_d = SRPC_ST_RUN;
      default: st_d = SRPC_ST_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= SRPC_MODE_IDLE;
    end else if (st_q == SRPC_ST_RUN && st_d == SRPC_ST_SLEEP) begin
      mode_q <= sleep_mode;
    end
  end

  // Oscillator start-up wait only where oscillator was stopped
  assign mode_q_en = mode_en(mode_q);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wcnt_q <= 16'h0;
    end else if (st_q == SRPC_ST_SLEEP && st_d == SRPC_ST_WAKE) begin
      wcnt_q <= mode_q_en.osc ? 16'h0 : 16'(OSC_START_CYC);
    end else if (wcnt_q != 16'h0) begin
      wcnt_q <= wcnt_q - 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_q <= '{cpu: 1'b0, io: 1'b0, async_tmr: 1'b0, adc: 1'b0, osc: 1'b1};
    end else begin
      case (st_d)
        SRPC_ST_RUN: en_q <= '{cpu: 1'b1, io: 1'b1, async_tmr: 1'b1, adc: 1'b1, osc: 1'b1};
        SRPC_ST_SLEEP: en_q <= mode_en(st_q == SRPC_ST_RUN ? sleep_mode : mode_q);
        SRPC_ST_WAKE: en_q <= '{cpu: 1'b0, io: 1'b1, async_tmr: 1'b1, adc: 1'b1, osc: 1'b1};
        default: en_q <= '{cpu: 1'b0, io: 1'b0, async_tmr: 1'b0, adc: 1'b0, osc: 1'b1};
      endcase
    end
  end

  // Pin drivers, all floating in reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_b_oe_n <= '1;
      port_c_oe_n <= '1;
      port_d_oe_n <= '1;
      port_b_pu_n <= '1;
      port_c_pu_n <= '1;
      port_d_pu_n <= '1;
      port_b_o <= '0;
      port_c_o <= '0;
      port_d_o <= '0;
    end else if (rst_any) begin
      port_b_oe_n <= '1;
      port_c_oe_n <= '1;
      port_d_oe_n <= '1;
      port_b_pu_n <= '1;
      port_c_pu_n <= '1;
      port_d_pu_n <= '1;
      port_b_o <= '0;
      port_c_o <= '0;
      port_d_o <= '0;
    end else begin
      port_b_oe_n <= ~(port_b_dir & ~b_shared);
      port_b_pu_n <= ~(port_b_pull & ~port_b_dir & ~b_shared);
      port_b_o <= port_b_out & ~b_shared;
      port_c_oe_n <= ~(port_c_dir & c_avail);
      port_c_pu_n <= ~(port_c_pull & ~port_c_dir & c_avail);
      port_c_o <= port_c_out & c_avail;
      port_d_oe_n <= ~port_d_dir;
      port_d_pu_n <= ~(port_d_pull & ~port_d_dir);
      port_d_o <= port_d_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      device_reset <= 1'b1;
      timer_crystal_pins <= 1'b0;
      main_osc_pins <= 1'b0;
    end else begin
      device_reset <= rst_any;
      timer_crystal_pins <= rc_osc_selected && async_timer_clock_select;
      main_osc_pins <= ext_osc_on_pins;
    end
  end

  assign clk_en = en_q;
  assign state = st_q;

  a_reset_floats: assert property (@(posedge clk) disable iff (!rstn)
    rif.rst_req |=> (&port_b_oe_n && &port_c_oe_n && &port_d_oe_n))
    else $error("pins driven during reset");
  a_idle_cpu_off: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_SLEEP && mode_q == SRPC_MODE_IDLE) |-> (!en_q.cpu && en_q.io))
    else $error("idle gating wrong");
  a_pdown_all_off: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_SLEEP && mode_q == SRPC_MODE_PDOWN) |-> (en_q == '0))
    else $error("power-down leaves clocks on");
  a_psave_timer_on: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_SLEEP && mode_q == SRPC_MODE_PSAVE) |-> (en_q.async_tmr && !en_q.io))
    else $error("power-save timer stopped");
  a_adcq_gating: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_SLEEP && mode_q == SRPC_MODE_ADCQ) |-> (en_q.adc && !en_q.io && !en_q.cpu))
    else $error("conversion-quiet gating wrong");
  a_stby_fast_wake: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_SLEEP && mode_q == SRPC_MODE_STBY && irq_pending && !rst_any)
    |=> ##1 (st_q == SRPC_ST_RUN)) else $error("standby wake too slow");
  a_wake_cpu_last: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == SRPC_ST_WAKE) |-> (!en_q.cpu && en_q.osc)) else $error("cpu before clocks");
  a_fuse_pin_mode: assert property (@(posedge clk) disable iff (!rstn)
    reset_pin_disable_fuse |-> !rif.pin_low) else $error("fused pin resets");
  a_crystal_pins: assert property (@(posedge clk) disable iff (!rstn)
    (rc_osc_selected && async_timer_clock_select && !rst_any) |=> port_b_oe_n[7:6] == 2'h3)
    else $error("crystal pins driven");
endmodule : srpc_top

// *** rtl/srpc_regs.svh ***
// Purpose: Constants for the sleep and reset-pin control block
// Assumes: 250 MHz clock
// Notes: Reset pin minimum pulse length is a parameter default
`ifndef SRPC_REGS_SVH
`define SRPC_REGS_SVH
`define SRPC_CLK_PERIOD_NS 4
`define SRPC_RST_MIN_PULSE_NS 2000
`define SRPC_RST_MIN_CYC ((`SRPC_RST_MIN_PULSE_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_OSC_START_NS 400
`define SRPC_OSC_START_CYC ((`SRPC_OSC_START_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_PORT_W 8
`define SRPC_PC_BIT_SIX 6
`define SRPC_PB_BIT_SIX 6
`define SRPC_PB_BIT_SEVEN 7
`endif

// *** rtl/srpc_pkg.sv ***
// Purpose: Types for the sleep and reset-pin control block
// Assumes: Nothing
// Notes: Sleep mode codes are the software encoding
package srpc_pkg;
  typedef enum logic [2:0] {
    SRPC_MODE_IDLE = 3'h0,
    SRPC_MODE_ADCQ = 3'h1,
    SRPC_MODE_PSAVE = 3'h2,
    SRPC_MODE_PDOWN = 3'h3,
    SRPC_MODE_STBY = 3'h4
  } srpc_mode_t;
  typedef enum logic [3:0] {
    SRPC_ST_RUN = 4'h1,
    SRPC_ST_SLEEP = 4'h2,
    SRPC_ST_WAKE = 4'h4,
    SRPC_ST_RST = 4'h8
  } srpc_state_t;
  typedef struct packed {
    logic cpu;
    logic io;
    logic async_tmr;
    logic adc;
    logic osc;
  } srpc_clk_en_t;
endpackage : srpc_pkg

// *** rtl/srpc_if.sv ***
// Purpose: Reset pin filter carrier
// Assumes: Single clock
// Notes: Joins top and reset filter
`timescale 1ns/1ps
interface srpc_rst_if;
  logic pin_low;
  logic rst_req;
  modport filt (input pin_low, output rst_req);
  modport top (output pin_low, input rst_req);
endinterface : srpc_rst_if

// *** rtl/srpc_rst_filter.sv ***
// Purpose: Reset pin low-pulse qualifier
// Assumes: Pin sampled synchronously
// Notes: Request stands while pin stays low after the minimum length
`timescale 1ns/1ps
`include "srpc_regs.svh"
module srpc_rst_filter #(
  parameter int MIN_CYC = `SRPC_RST_MIN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  srpc_rst_if.filt rif
);
  logic [15:0] cnt_q;
  logic req_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 16'h0;
    end else if (!rif.pin_low) begin
      cnt_q <= 16'h0;
    end else if (cnt_q != 16'(MIN_CYC)) begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= rif.pin_low && (cnt_q == 16'(MIN_CYC));
    end
  end
  assign rif.rst_req = req_q;
  a_pulse_len_req: assert property (@(posedge clk) disable iff (!rstn)
    $rose(req_q) |-> $past(rif.pin_low)) else $error("reset request without low pin");
endmodule : srpc_rst_filter

// *** bench/srpc_board.sv ***
// Purpose: Board reset source and timer crystal model
// Assumes: Reset line has a pull-up
// Notes: Crystal stands still while switched off
`timescale 1ns/1ps
module srpc_board (
  // Clock and commands
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic xtal_on,
  // Board lines
  output logic rst_pin_n,
  output logic [1:0] xtal
);
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] xtal_q = 2'h1;
  // Holds the line low for len cycles
  always_ff @(posedge clk) begin
    if (go) cnt_q <= len;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  always_ff @(posedge clk) xtal_q <= xtal_on ? ~xtal_q : xtal_q;
  assign rst_pin_n = (cnt_q == 8'h00);
  assign xtal = xtal_q;
endmodule : srpc_board

// *** bench/srpc_top_tb.sv ***
// Purpose: Self-checking bench for sleep and reset-pin control
// Assumes: Short reset and start-up counts
// Notes: No random stimulus
`timescale 1ns/1ps
module srpc_top_tb;
  import srpc_pkg::*;
  localparam int RMIN = 4;
  localparam int OSC = 3;
  localparam logic [4:0] EXP [5] = '{5'h0f, 5'h07, 5'h04, 5'h00, 5'h01};
  localparam logic [4:0] MSK [5] = '{5'h1f, 5'h1f, 5'h1e, 5'h1f, 5'h1f};
  logic clk = 1'b0, rstn = 1'b0, sen = 1'b1, sreq = 1'b0, irq = 1'b0, oth = 1'b0;
  logic fuse = 1'b0, rc = 1'b0, ext = 1'b0, asel = 1'b0, go = 1'b0, rst_pin_n;
  srpc_mode_t mode = SRPC_MODE_IDLE;
  logic [7:0] dir = 8'h0f, out = 8'ha5, pull = 8'hf0, len = 8'h00;
  logic [7:0] bo, b_oe_n, b_pu_n, co, c_oe_n, c_pu_n, dout, d_oe_n, d_pu_n;
  logic [1:0] xtal;
  logic dres, tpins, mpins;
  srpc_clk_en_t en;
  srpc_state_t state;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #2 clk = ~clk;
  srpc_board board (.clk(clk), .go(go), .len(len), .xtal_on(asel), .rst_pin_n(rst_pin_n),
    .xtal(xtal));
  srpc_top #(.RST_MIN_CYC(RMIN), .OSC_START_CYC(OSC)) dut (.clk(clk), .rstn(rstn),
    .sleep_enable(sen), .sleep_req(sreq), .sleep_mode(mode), .irq_pending(irq),
    .other_reset(oth), .reset_pin_disable_fuse(fuse), .rc_osc_selected(rc),
    .ext_osc_on_pins(ext), .async_timer_clock_select(asel), .port_b_out(out),
    .port_b_dir(dir), .port_b_pull(pull), .port_c_out(out), .port_c_dir(dir),
    .port_c_pull(pull), .port_d_out(out), .port_d_dir(dir), .port_d_pull(pull),
    .port_b_in({xtal, 6'h15}), .port_c_in({1'b1, rst_pin_n, 6'h2a}), .port_d_in(8'h3c),
    .port_b_o(bo), .port_b_oe_n(b_oe_n), .port_b_pu_n(b_pu_n), .port_c_o(co),
    .port_c_oe_n(c_oe_n), .port_c_pu_n(c_pu_n), .port_d_o(dout), .port_d_oe_n(d_oe_n),
    .port_d_pu_n(d_pu_n), .device_reset(dres), .timer_crystal_pins(tpins),
    .main_osc_pins(mpins), .clk_en(en), .state(state));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic smp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : smp
  task automatic wait_st(input srpc_state_t s, input int lim, output int n);
    n = 0;
    while (state !== s && n < lim) begin
      smp(1);
      n++;
    end
  endtask : wait_st
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_reset();
    int n;
    @(posedge clk);
    rstn <= 1'b0;
    smp(4);
    chk({7'h0, dres}, 8'h01);
    chk(b_oe_n & c_oe_n & d_oe_n, 8'hff);
    chk(b_pu_n & c_pu_n & d_pu_n, 8'hff);
    chk({4'h0, state}, {4'h0, SRPC_ST_RST});
    @(posedge clk);
    rstn <= 1'b1;
    wait_st(SRPC_ST_RUN, 4, n);
    chk({4'h0, state}, {4'h0, SRPC_ST_RUN});
    chk({7'h0, dres}, 8'h00);
    chk({3'h0, en}, 8'h1f);
    $display("reset test done");
  endtask : t_reset
  task automatic t_sleep(input int m);
    int n;
    @(posedge clk);
    mode <= srpc_mode_t'(m);
    sreq <= 1'b1;
    @(posedge clk);
    sreq <= 1'b0;
    wait_st(SRPC_ST_SLEEP, 4, n);
    chk({4'h0, state}, {4'h0, SRPC_ST_SLEEP});
    chk({3'h0, en & MSK[m]}, {3'h0, EXP[m]});
    smp(3);
    chk({4'h0, state}, {4'h0, SRPC_ST_SLEEP});
    @(posedge clk);
    irq <= 1'b1;
    smp(1);
    chk({6'h0, state == SRPC_ST_WAKE, en.cpu}, 8'h02);
    chk({6'h0, en.osc, en.io}, 8'h03);
    wait_st(SRPC_ST_RUN, OSC + 6, n);
    chk({3'h0, en}, 8'h1f);
    chk({4'h0, state}, {4'h0, SRPC_ST_RUN});
    if (m == 2 || m == 3) chk(8'(n), 8'(OSC + 1));
    else chk(8'(n), 8'h01);
    @(posedge clk);
    irq <= 1'b0;
    $display("sleep mode %0d test done", m);
  endtask : t_sleep
  task automatic t_refuse();
    @(posedge clk);
    sen <= 1'b0;
    sreq <= 1'b1;
    @(posedge clk);
    sen <= 1'b1;
    mode <= srpc_mode_t'(3'h5);
    @(posedge clk);
    sreq <= 1'b0;
    smp(3);
    chk({4'h0, state}, {4'h0, SRPC_ST_RUN});
    $display("refusal test done");
  endtask : t_refuse
  task automatic t_ports(input logic f);
    @(posedge clk);
    fuse <= f;
    smp(3);
    chk(d_oe_n, ~dir);
    chk(d_pu_n, ~(pull & ~dir));
    chk(dout, out);
    chk(bo, out);
    chk(b_oe_n, ~dir);
    chk(b_pu_n, ~(pull & ~dir));
    chk(co, out & (f ? 8'h7f : 8'h3f));
    chk(c_oe_n, ~(dir & (f ? 8'h7f : 8'h3f)));
    chk(c_pu_n, ~(pull & ~dir & (f ? 8'h7f : 8'h3f)));
    chk({6'h0, c_pu_n[7:6]}, {6'h0, 1'b1, ~f});
    $display("port test done");
  endtask : t_ports
  task automatic t_osc();
    @(posedge clk);
    dir <= 8'hff;
    ext <= 1'b1;
    smp(3);
    chk({5'h0, mpins, b_oe_n[7:6]}, 8'h07);
    chk({6'h0, bo[7:6]}, 8'h00);
    @(posedge clk);
    ext <= 1'b0;
    rc <= 1'b1;
    asel <= 1'b1;
    smp(3);
    chk({5'h0, tpins, b_oe_n[7:6]}, 8'h07);
    chk({7'h0, mpins}, 8'h00);
    @(posedge clk);
    asel <= 1'b0;
    smp(3);
    chk({4'h0, tpins, mpins, b_oe_n[7:6]}, 8'h00);
    @(posedge clk);
    dir <= 8'h0f;
    rc <= 1'b0;
    $display("oscillator pin test done");
  endtask : t_osc
  task automatic t_pin(input logic f, input logic [7:0] l, input logic exp);
    int n;
    @(posedge clk);
    fuse <= f;
    go <= 1'b1;
    len <= l;
    @(posedge clk);
    go <= 1'b0;
    smp(RMIN + 5);
    chk({7'h0, dres}, {7'h0, exp});
    chk(d_oe_n & b_oe_n, exp ? 8'hff : ~dir);
    wait_st(SRPC_ST_RUN, 40, n);
    chk({4'h0, state}, {4'h0, SRPC_ST_RUN});
    $display("reset pin test done");
  endtask : t_pin
  task automatic t_other();
    int n;
    @(posedge clk);
    oth <= 1'b1;
    smp(3);
    chk({7'h0, dres}, 8'h01);
    chk(d_oe_n & b_oe_n & c_oe_n, 8'hff);
    chk(d_pu_n & b_pu_n & c_pu_n, 8'hff);
    @(posedge clk);
    oth <= 1'b0;
    wait_st(SRPC_ST_RUN, 8, n);
    chk({4'h0, state}, {4'h0, SRPC_ST_RUN});
    $display("other reset test done");
  endtask : t_other
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    t_reset();
    for (int m = 0; m < 5; m++) t_sleep(m);
    t_refuse();
    t_ports(1'b0);
    t_ports(1'b1);
    t_osc();
    t_pin(1'b0, 8'h02, 1'b0);
    t_pin(1'b0, 8'h0e, 1'b1);
    t_pin(1'b1, 8'h0e, 1'b0);
    t_other();
    t_reset();
    give_verdict();
  end
endmodule : srpc_top_tb
